// *** src/pcs_config_regs.sv ***
//Behaviour
// - Address or data parity error sets bit 15
// - Enabled signaled system error sets bit 14
// - Master abort on own cycle sets 13
// - Target abort on own cycle sets 12
// - Own target abort sets bit 11
// - Event flags sticky, other status bits read-only
// - Bits 10:9 read 01b, medium select timing
// - Bit 8: PERR, we master, response enabled
// - Bits 7 and 6 read zero
// - Bit 5 reads one, 66 MHz
// - Bit 4 reads one, capability list
// - Bit 3 mirrors interrupt; INTx gated by inhibit
// - Inhibit leaves interrupt status bit untouched
// - Status bits 2:0 read zero
// - Class bits 31:24 read 0Ch
// - Class bits 23:16 fixed 1394 subclass
// - Class bits 15:8 read 10h
// - Class low byte is silicon revision
// - Command bit 10 inhibits interrupt output
// - Command bit 6 enables parity response
`timescale 1ns/1ps
module pcs_config_regs
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic parity_error_evt,
    input wire logic system_error_evt,
    input wire logic master_abort_evt,
    input wire logic target_abort_rcvd_evt,
    input wire logic target_abort_sent_evt,
    input wire logic perr_seen_evt,
    input wire logic bus_master_active,
    input wire logic int_condition,
    output logic intx_assert,
    output logic serr_enable,
    output logic parity_response_enable,
    output logic [7:0] latency_timer,
    output logic [7:0] cache_line_size
);

    // ****************************************
    // State
    // ****************************************
    pcs_main_s cur;
    pcs_main_s next_cur;

    logic [15:0] flag_set;
    logic [15:0] flag_clear;
    logic [15:0] flag_q;
    logic [15:0] status_word;
    logic [31:0] class_word;
    logic [15:0] cmd_merged;
    logic [15:0] cache_lat_merged;
    logic [15:0] cmd_writable;
    logic take;
    logic write_cmd_dw;
    logic write_cache_dw;
    logic [5:0] dw_index;

    assign dw_index = cfg_addr[7:2];
    assign take = cfg_req && (cur.state == ST_IDLE);
    assign write_cmd_dw = take && cfg_write && (dw_index == CMD_DW);
    assign write_cache_dw = take && cfg_write && (dw_index == CACHE_LAT_DW);

    // ****************************************
    // Status event flags
    // ****************************************
    always_comb begin
        flag_set = '0;
        flag_set[ST_DETECTED_PARITY] = parity_error_evt;
        flag_set[ST_SIGNALED_SERR] = system_error_evt && cur.command[CMD_SERR_EN];
        flag_set[ST_RCVD_MASTER_ABORT] = master_abort_evt;
        flag_set[ST_RCVD_TARGET_ABORT] = target_abort_rcvd_evt;
        flag_set[ST_SIGNALED_TARGET_ABORT] = target_abort_sent_evt;
        // master data parity, all three conditions
        flag_set[ST_MASTER_DATA_PARITY] = perr_seen_evt && bus_master_active &&
            cur.command[CMD_PARITY_RESPONSE_ENABLE];
    end

    // write one to clear, per byte lane
    assign flag_clear = write_cmd_dw ?
        (cfg_wdata[31:16] & {{LANE_W{cfg_byte_en[3]}}, {LANE_W{cfg_byte_en[2]}}}) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (STATUS_FLAG_MASK[gi]) begin : g_sticky
                pcs_sticky_flag u_flag (
                    .clk(clk),
                    .arst_n(arst_n),
                    .set_evt(flag_set[gi]),
                    .clear_req(flag_clear[gi]),
                    .flag(flag_q[gi])
                );
            end else begin : g_none
                assign flag_q[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************
    // Read-only words
    // ****************************************
    always_comb begin
        status_word = STATUS_FIXED | (flag_q & STATUS_FLAG_MASK);
        status_word[10:9] = SELECT_TIMING_CODE;
        // live interrupt condition, inhibit ignored here
        status_word[ST_INT_STATUS] = int_condition;
    end

    assign class_word = {BASE_CATEGORY, SUBCLASS_SERIAL_1394,
                         PROGRAMMING_MODEL_CODE, SILICON_REVISION};

    // ****************************************
    // Byte-lane writes
    // ****************************************
    pcs_lane_merge #(
        .LANES(2)
    ) u_cmd_merge (
        .old_value(cur.command),
        .new_value(cfg_wdata[15:0]),
        .lane_en(cfg_byte_en[1:0]),
        .merged(cmd_merged)
    );

    pcs_lane_merge #(
        .LANES(2)
    ) u_cache_merge (
        .old_value(cur.cache_lat),
        .new_value(cfg_wdata[15:0]),
        .lane_en(cfg_byte_en[1:0]),
        .merged(cache_lat_merged)
    );

    // Only the controls this block uses are kept; the rest read zero
    always_comb begin
        cmd_writable = '0;
        cmd_writable[CMD_INT_INHIBIT] = cmd_merged[CMD_INT_INHIBIT];
        cmd_writable[CMD_SERR_EN] = cmd_merged[CMD_SERR_EN];
        cmd_writable[CMD_PARITY_RESPONSE_ENABLE] = cmd_merged[CMD_PARITY_RESPONSE_ENABLE];
    end

    // ****************************************
    // Access sequencer
    // ****************************************
    always_comb begin
        next_cur = cur;
        next_cur.ack = 1'b0;
        // INTx only when pending and not inhibited
        next_cur.intx = int_condition && !cur.command[CMD_INT_INHIBIT];
        case (cur.state)
            ST_IDLE: begin
                if (cfg_req) begin
                    next_cur.state = ST_ANSWER;
                    next_cur.ack = 1'b1;
                    next_cur.rdata = '0;
                    if (!cfg_write) begin
                        case (dw_index)
                            CMD_DW: begin
                                next_cur.rdata = {status_word, cur.command};
                            end
                            CLASS_DW: begin
                                next_cur.rdata = class_word;
                            end
                            CACHE_LAT_DW: begin
                                // Upper half is header type and no self-test
                                next_cur.rdata = {16'h0000, cur.cache_lat};
                            end
                            default: begin
                                next_cur.rdata = '0;
                            end
                        endcase
                    end
                    if (write_cmd_dw) begin
                        next_cur.command = cmd_writable;
                    end
                    // cache line and latency written by firmware
                    if (write_cache_dw) begin
                        next_cur.cache_lat = cache_lat_merged;
                    end
                end
            end
            ST_ANSWER: begin
                // One idle cycle between accesses keeps the decode simple
                next_cur.state = ST_IDLE;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur.state <= ST_IDLE;
            cur.ack <= 1'b0;
            cur.rdata <= '0;
            cur.command <= CMD_RESET;
            cur.cache_lat <= CACHE_LAT_RESET;
            cur.intx <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cfg_ack = cur.ack;
    assign cfg_rdata = cur.rdata;
    assign intx_assert = cur.intx;
    assign serr_enable = cur.command[CMD_SERR_EN];
    assign parity_response_enable = cur.command[CMD_PARITY_RESPONSE_ENABLE];
    assign latency_timer = cur.cache_lat[15:8];
    assign cache_line_size = cur.cache_lat[7:0];

endmodule : pcs_config_regs

// *** inc/pcs_pkg.sv ***
package pcs_pkg;

    // ****************************************
    // Configuration offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h06;
    localparam logic [7:0] CLASS_OFS = 8'h08;
    localparam logic [7:0] CACHE_LAT_OFS = 8'h0c;
    localparam logic [5:0] CMD_DW = CMD_OFS[7:2];
    localparam logic [5:0] CLASS_DW = CLASS_OFS[7:2];
    localparam logic [5:0] CACHE_LAT_DW = CACHE_LAT_OFS[7:2];
    localparam int unsigned STATUS_SHIFT = 16;
    localparam int unsigned LANE_W = 8;

    // ****************************************
    // Command register fields
    // ****************************************
    localparam int unsigned CMD_INT_INHIBIT = 10;
    localparam int unsigned CMD_SERR_EN = 8;
    localparam int unsigned CMD_PARITY_RESPONSE_ENABLE = 6;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int unsigned ST_DETECTED_PARITY = 15;
    localparam int unsigned ST_SIGNALED_SERR = 14;
    localparam int unsigned ST_RCVD_MASTER_ABORT = 13;
    localparam int unsigned ST_RCVD_TARGET_ABORT = 12;
    localparam int unsigned ST_SIGNALED_TARGET_ABORT = 11;
    localparam int unsigned ST_MASTER_DATA_PARITY = 8;
    localparam int unsigned ST_INT_STATUS = 3;
    localparam logic [15:0] STATUS_RESET = 16'h0230;
    localparam logic [15:0] STATUS_FLAG_MASK = 16'hf900;
    localparam logic [1:0] SELECT_TIMING_CODE = 2'h1;
    localparam logic [15:0] STATUS_FIXED = 16'h0230;

    // ****************************************
    // Class code and revision
    // ****************************************
    localparam logic [7:0] BASE_CATEGORY = 8'h0c;
    localparam logic [7:0] SUBCLASS_SERIAL_1394 = 8'h00;
    localparam logic [7:0] PROGRAMMING_MODEL_CODE = 8'h10;
    // Arbitrary value, replaced per tape-out
    localparam logic [7:0] SILICON_REVISION = 8'h5a;

    localparam logic [15:0] CACHE_LAT_RESET = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANSWER = 2'b10
    } pcs_state_e;

    typedef struct packed {
        pcs_state_e state;
        logic ack;
        logic [31:0] rdata;
        logic [15:0] command;
        logic [15:0] cache_lat;
        logic intx;
    } pcs_main_s;

    typedef struct packed {
        logic flag;
    } pcs_flag_s;

endpackage : pcs_pkg

// *** src/pcs_sticky_flag.sv ***
`timescale 1ns/1ps
module pcs_sticky_flag
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic set_evt,
    input wire logic clear_req,
    output logic flag
);

    pcs_flag_s cur;
    pcs_flag_s next_cur;

    always_comb begin
        next_cur = cur;
        // Set beats a clear in the same cycle so no event is lost
        if (set_evt) begin
            next_cur.flag = 1'b1;
        end else if (clear_req) begin
            next_cur.flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign flag = cur.flag;

endmodule : pcs_sticky_flag

// *** src/pcs_lane_merge.sv ***
`timescale 1ns/1ps
module pcs_lane_merge
    import pcs_pkg::*;
#(
    parameter int unsigned LANES = 2
) (
    input wire logic [LANES*LANE_W-1:0] old_value,
    input wire logic [LANES*LANE_W-1:0] new_value,
    input wire logic [LANES-1:0] lane_en,
    output logic [LANES*LANE_W-1:0] merged
);

    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            assign merged[i*LANE_W +: LANE_W] = lane_en[i] ?
                new_value[i*LANE_W +: LANE_W] : old_value[i*LANE_W +: LANE_W];
        end
    endgenerate

endmodule : pcs_lane_merge

// *** tb/pcs_config_regs_props.sv ***
`timescale 1ns/1ps
module pcs_config_regs_props
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic parity_error_evt,
    input wire logic system_error_evt,
    input wire logic master_abort_evt,
    input wire logic perr_seen_evt,
    input wire logic bus_master_active,
    input wire logic int_condition,
    input wire logic intx_assert,
    input wire logic serr_enable,
    input wire logic parity_response_enable
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic take;
    logic rd_st;
    // A request only counts while no answer is pending
    assign take = cfg_req && !cfg_ack;
    assign rd_st = take && !cfg_write && cfg_addr[7:2] == CMD_DW;
    property p_ack; take |=> cfg_ack ##1 !cfg_ack; endproperty
    a_ack: assert property (p_ack) else $error("answer timing wrong");
    property p_fixed; rd_st |=> (cfg_rdata[26:16] & 11'h6f7) == 11'h230; endproperty
    a_fixed: assert property (p_fixed) else $error("hardwired status bits wrong");
    property p_intbit; rd_st |=> cfg_rdata[19] == $past(int_condition); endproperty
    a_intbit: assert property (p_intbit) else $error("interrupt status bit wrong");
    property p_intx; intx_assert |-> $past(int_condition); endproperty
    a_intx: assert property (p_intx) else $error("interrupt without condition");
    property p_class;
        take && !cfg_write && cfg_addr[7:2] == CLASS_DW |=> cfg_rdata ==
            {8'h0c, SUBCLASS_SERIAL_1394, 8'h10, SILICON_REVISION};
    endproperty
    a_class: assert property (p_class) else $error("class word wrong");
    property p_par; parity_error_evt ##[1:2] rd_st |=> cfg_rdata[31]; endproperty
    a_par: assert property (p_par) else $error("parity flag not set");
    property p_serr; system_error_evt && serr_enable ##[1:2] rd_st |=> cfg_rdata[30]; endproperty
    a_serr: assert property (p_serr) else $error("system error flag not set");
    property p_mab; master_abort_evt ##[1:2] rd_st |=> cfg_rdata[29]; endproperty
    a_mab: assert property (p_mab) else $error("master abort flag not set");
    property p_dpar;
        perr_seen_evt && bus_master_active && parity_response_enable ##[1:2] rd_st
            |=> cfg_rdata[24];
    endproperty
    a_dpar: assert property (p_dpar) else $error("data parity flag not set");
    property p_pen;
        take && cfg_write && cfg_addr[7:2] == CMD_DW && cfg_byte_en[0]
            |=> parity_response_enable == $past(cfg_wdata[6]);
    endproperty
    a_pen: assert property (p_pen) else $error("parity enable not written");
    c_class: cover property (take && cfg_addr[7:2] == CLASS_DW);
    c_intx: cover property (intx_assert);
    c_par: cover property (parity_error_evt ##[1:2] rd_st);
endmodule : pcs_config_regs_props

bind pcs_config_regs pcs_config_regs_props pcs_config_regs_props_inst (.clk, .arst_n,
    .cfg_req, .cfg_write, .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_ack, .cfg_rdata,
    .parity_error_evt, .system_error_evt, .master_abort_evt, .perr_seen_evt,
    .bus_master_active, .int_condition, .intx_assert, .serr_enable, .parity_response_enable);

// *** tb/pcs_host_model.sv ***
`timescale 1ns/1ps
module pcs_host_model (
    input wire logic clk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_req,
    output logic cfg_write,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata
);
    // ****************************************
    // Configuration host
    // ****************************************
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0;
    end
    // Held until answered or four edges pass; released address and data scrambled so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] e,
                        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_addr = a;
        cfg_byte_en = e;
        cfg_wdata = d;
        // Request stands until the edge that samples the answer high
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            if (cfg_ack === 1'b1) begin
                break;
            end
        end
        q = cfg_rdata;
        @(negedge clk);
        cfg_req = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~d;
    endtask : xfer
    task automatic program_cache(input logic [15:0] v);
        logic [31:0] q;
        xfer(1'b1, 8'h0c, 4'h3, {16'h0, v}, q);
    endtask : program_cache
endmodule : pcs_host_model

// *** tb/pcs_config_regs_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: %h not %h", $time, a, b); end end
module pcs_config_regs_tb_top
    import pcs_pkg::*;
;
    logic clk;
    logic arst_n;
    logic req, wr, ack, bm, intc, intx, se, pe;
    logic [5:0] evt;
    logic [7:0] addr, lat, cls;
    logic [3:0] be;
    logic [31:0] wd, rd, q, lf;
    logic [15:0] sh;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int pos_t[6] = '{15, 14, 13, 12, 11, 8};
    pcs_config_regs pcs_config_regs_inst (.clk(clk), .arst_n(arst_n), .cfg_req(req),
        .cfg_write(wr), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wd), .cfg_ack(ack),
        .cfg_rdata(rd), .parity_error_evt(evt[0]), .system_error_evt(evt[1]),
        .master_abort_evt(evt[2]), .target_abort_rcvd_evt(evt[3]),
        .target_abort_sent_evt(evt[4]), .perr_seen_evt(evt[5]), .bus_master_active(bm),
        .int_condition(intc), .intx_assert(intx), .serr_enable(se),
        .parity_response_enable(pe), .latency_timer(lat), .cache_line_size(cls));
    pcs_host_model pcs_host_model_inst (.clk(clk), .cfg_ack(ack), .cfg_rdata(rd),
        .cfg_req(req), .cfg_write(wr), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wd));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] st(input logic [15:0] f, input logic i);
        return 16'h0230 | f | {12'h0, i, 3'h0};
    endfunction : st
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                          input logic [1:0] e);
        return {e[1] ? n[15:8] : o[15:8], e[0] ? n[7:0] : o[7:0]};
    endfunction : merge
    task automatic rdw(input logic [7:0] a);
        pcs_host_model_inst.xfer(1'b0, a, 4'h0, 32'h0, q);
    endtask : rdw
    task automatic wrw(input logic [7:0] a, input logic [3:0] e, input logic [31:0] d);
        pcs_host_model_inst.xfer(1'b1, a, e, d, q);
    endtask : wrw
    // One-cycle event pulse, then status read
    task automatic flag(input logic [5:0] v);
        @(negedge clk);
        evt = v;
        @(negedge clk);
        evt = 6'h0;
        rdw(CMD_OFS);
    endtask : flag
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        arst_n = 1'b0;
        evt = 6'h0;
        bm = 1'b1;
        intc = 1'b0;
        lf = 32'd73949;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        rdw(CMD_OFS);
        `CHK(q, 32'h0230_0000)
        rdw(CACHE_LAT_OFS);
        `CHK(q, 32'h0)
        wrw(CLASS_OFS, 4'hf, 32'h0);
        rdw(CLASS_OFS);
        `CHK(q, {8'h0c, SUBCLASS_SERIAL_1394, 8'h10, SILICON_REVISION})
        rdw(8'h40);
        `CHK(q, 32'h0)
        wrw(CMD_OFS, 4'h3, 32'h0140);
        `CHK({se, pe}, 2'b11)
        for (int i = 0; i < 6; i++) begin
            flag(6'h1 << i);
            `CHK(q[31:16], st(16'h1 << pos_t[i], 1'b0))
            wrw(CMD_OFS, 4'hc, ~(32'h1 << (pos_t[i] + 16)));
            rdw(CMD_OFS);
            `CHK(q[31:16], st(16'h1 << pos_t[i], 1'b0))
            wrw(CMD_OFS, 4'hc, 32'h1 << (pos_t[i] + 16));
            rdw(CMD_OFS);
            `CHK(q[31:16], 16'h0230)
        end
        wrw(CMD_OFS, 4'h3, 32'h0);
        flag(6'h22);
        `CHK(q[31:16], 16'h0230)
        wrw(CMD_OFS, 4'h3, 32'h0040);
        bm = 1'b0;
        flag(6'h20);
        `CHK(q[31:16], 16'h0230)
        intc = 1'b1;
        rdw(CMD_OFS);
        `CHK({q[19], intx}, 2'b11)
        wrw(CMD_OFS, 4'h3, 32'h0400);
        rdw(CMD_OFS);
        `CHK({q[19], q[10], intx}, 3'b110)
        intc = 1'b0;
        pcs_host_model_inst.program_cache(16'h4010);
        sh = 16'h4010;
        repeat (40) begin
            lf = lfsr(lf);
            wrw(CACHE_LAT_OFS, lf[3:0], lf);
            sh = merge(sh, lf[15:0], lf[1:0]);
            rdw(CACHE_LAT_OFS);
            `CHK(q, {16'h0, sh})
            `CHK({lat, cls}, sh)
        end
        close_out();
    end
endmodule : pcs_config_regs_tb_top
